/* File: aac_action_count_unit.sv */
// acl action and count unit: action table, count timers and interrupts
`timescale 1ns/1ns
module aac_action_count_unit #(
   parameter int MS_CYCLES = aac_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic                      mclk,
   input  wire logic                      reset,
   // register port
   input  wire logic [aac_pkg::ADDR_W-1:0] addr,
   input  wire logic [aac_pkg::DATA_W-1:0] wrData,
   input  wire logic                      wrEn,
   input  wire logic                      rdEn,
   output logic      [aac_pkg::DATA_W-1:0] rdData,
   // frame from lookup and classification
   input  wire logic                      frmValid,
   input  wire logic [2:0]                frmPort,
   input  wire logic                      actHit,
   input  wire logic [3:0]                actIdx,
   input  wire logic [aac_pkg::TBL_DEPTH-1:0] cntHit,
   input  wire logic [2:0]                qosPri,
   input  wire logic [2:0]                framePcp,
   input  wire logic [aac_pkg::NPORT-1:0] lookupMap,
   // action result
   output logic                           resValid,
   output logic      [2:0]                resPri,
   output logic      [2:0]                resPcp,
   output logic      [aac_pkg::NPORT-1:0] resMap,
   // interrupt
   output logic                           irq
);

   // ----------------------------------------------------------------
   // state and helpers
   // ----------------------------------------------------------------
   aac_pkg::aac_state_t                 stReg;
   aac_pkg::aac_state_t                 stNext;
   logic [aac_pkg::ENTRY_W-1:0]         curEntry;
   logic                                portOk;
   logic                                entryLive;
   logic                                entryCount;
   logic [1:0]                          curPm;
   logic [2:0]                          curPri;
   logic [1:0]                          curMm;
   logic [aac_pkg::NPORT-1:0]           curFwd;
   logic                                actApply;
   logic                                usTick;
   logic                                msTick;
   logic [aac_pkg::NPORT-1:0]           evPort;
   logic [aac_pkg::NPORT-1:0]           statusClr;

   assign portOk     = frmPort < 3'(aac_pkg::NPORT);
   assign curEntry   = portOk ? stReg.tbl[7'({frmPort, actIdx})] : '0;
   assign entryLive  = curEntry[aac_pkg::F_MMODE_LSB +: 2] != aac_pkg::MODE_OFF;
   assign entryCount = curEntry[aac_pkg::F_MMODE_LSB +: 2] == aac_pkg::MODE_L2
                       && curEntry[aac_pkg::F_MSEL_LSB +: 2] == aac_pkg::SEL_COUNT;
   assign curPm      = curEntry[aac_pkg::F_PMODE_LSB +: 2];
   assign curPri     = curEntry[aac_pkg::F_PRI_LSB +: 3];
   assign curMm      = curEntry[aac_pkg::F_MAPM_LSB +: 2];
   assign curFwd     = curEntry[aac_pkg::F_FWD_LSB +: aac_pkg::NPORT];
   // count-mode entries carry count parameters, never forwarding actions
   assign actApply   = frmValid && actHit && portOk && entryLive && !entryCount;
   assign statusClr  = (wrEn && addr == aac_pkg::ADDR_PORT_STATUS)
                       ? wrData[aac_pkg::NPORT-1:0] : '0;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      stNext = stReg;
      evPort = '0;

      // microsecond and millisecond tick enables
      usTick = stReg.usDiv == 5'(aac_pkg::US_CYCLES - 1);
      msTick = stReg.msDiv == 16'(MS_CYCLES - 1);
      stNext.usDiv = usTick ? 5'h00 : 5'(stReg.usDiv + 5'h01);
      stNext.msDiv = msTick ? 16'h0000 : 16'(stReg.msDiv + 16'h0001);

      // count engine, one slot per table entry of every port
      for (int i = 0; i < aac_pkg::TBL_ENTRIES; i++) begin
         if (stReg.tbl[i][aac_pkg::F_MMODE_LSB +: 2] == aac_pkg::MODE_L2
             && stReg.tbl[i][aac_pkg::F_MSEL_LSB +: 2] == aac_pkg::SEL_COUNT) begin
            if (stReg.tbl[i][aac_pkg::F_ALGO]) begin
               // frame counting, time units unused
               if (frmValid && frmPort == 3'(i / aac_pkg::TBL_DEPTH)
                   && cntHit[i % aac_pkg::TBL_DEPTH]) begin
                  if (11'(stReg.cnt[i] + 11'h001)
                      == stReg.tbl[i][aac_pkg::F_COUNT_LSB +: aac_pkg::CNT_W]) begin
                     evPort[i / aac_pkg::TBL_DEPTH] = 1'b1;
                     stNext.cnt[i] = 11'h000;
                  end else begin
                     stNext.cnt[i] = 11'(stReg.cnt[i] + 11'h001);
                  end
               end
               stNext.armed[i] = 1'b0;
            end else begin
               // gap timeout between matching frames
               if (frmValid && frmPort == 3'(i / aac_pkg::TBL_DEPTH)
                   && cntHit[i % aac_pkg::TBL_DEPTH]) begin
                  stNext.cnt[i]   = stReg.tbl[i][aac_pkg::F_COUNT_LSB +: aac_pkg::CNT_W];
                  stNext.armed[i] = 1'b1;
               end else if (stReg.armed[i]
                            && (stReg.tbl[i][aac_pkg::F_TUNIT] ? msTick : usTick)) begin
                  if (stReg.cnt[i] <= 11'h001) begin
                     evPort[i / aac_pkg::TBL_DEPTH] = 1'b1;
                     stNext.armed[i] = 1'b0;
                     stNext.cnt[i]   = 11'h000;
                  end else begin
                     stNext.cnt[i] = 11'(stReg.cnt[i] - 11'h001);
                  end
               end
            end
         end else begin
            // disabled or filtering entry: no counting
            stNext.cnt[i]   = 11'h000;
            stNext.armed[i] = 1'b0;
         end
      end

      // register writes; a table write restarts that entry's counter
      if (wrEn) begin
         if (addr < 8'(aac_pkg::TBL_ENTRIES)) begin
            stNext.tbl[addr[6:0]]   = wrData[aac_pkg::ENTRY_W-1:0];
            stNext.cnt[addr[6:0]]   = 11'h000;
            stNext.armed[addr[6:0]] = 1'b0;
         end else if (addr == aac_pkg::ADDR_PORT_MASK) begin
            stNext.portMask = wrData[aac_pkg::NPORT-1:0];
         end else if (addr == aac_pkg::ADDR_GLOB_MASK) begin
            stNext.globalMask = wrData[aac_pkg::NPORT-1:0];
         end
      end

      // sticky status, a new event wins over a clear
      stNext.portStatus = (stReg.portStatus & ~statusClr) | evPort;

      // frame actions
      stNext.resValid = frmValid && portOk;
      stNext.resPri   = qosPri;
      stNext.resPcp   = framePcp;
      stNext.resMap   = lookupMap;
      if (actApply) begin
         case (curPm)
            aac_pkg::SEL_RAISE: begin
               if (curPri > qosPri) begin
                  stNext.resPri = curPri;
               end
            end
            aac_pkg::SEL_LOWER: begin
               if (curPri < qosPri) begin
                  stNext.resPri = curPri;
               end
            end
            aac_pkg::SEL_ALWAYS: begin
               stNext.resPri = curPri;
            end
            default: begin
               stNext.resPri = qosPri;
            end
         endcase
         if (curEntry[aac_pkg::F_REMARK_EN]) begin
            stNext.resPcp = curEntry[aac_pkg::F_RPRI_LSB +: 3];
         end
         // bit n of either map is port n+1
         case (curMm)
            aac_pkg::SEL_RAISE: begin
               stNext.resMap = lookupMap | curFwd;
            end
            aac_pkg::SEL_LOWER: begin
               stNext.resMap = lookupMap & curFwd;
            end
            aac_pkg::SEL_ALWAYS: begin
               stNext.resMap = curFwd;
            end
            default: begin
               stNext.resMap = lookupMap;
            end
         endcase
      end

      // interrupt output, two-level mask
      stNext.irq = |(stNext.portStatus & stNext.portMask & stNext.globalMask);

      // read data, valid the cycle after the strobe only
      stNext.rdData = '0;
      if (rdEn) begin
         if (addr < 8'(aac_pkg::TBL_ENTRIES)) begin
            stNext.rdData = 32'(stReg.tbl[addr[6:0]]);
         end else begin
            case (addr)
               aac_pkg::ADDR_PORT_STATUS: begin
                  stNext.rdData = 32'(stReg.portStatus);
               end
               aac_pkg::ADDR_PORT_MASK: begin
                  stNext.rdData = 32'(stReg.portMask);
               end
               aac_pkg::ADDR_GLOB_STATUS: begin
                  stNext.rdData = 32'(stReg.portStatus & stReg.portMask);
               end
               aac_pkg::ADDR_GLOB_MASK: begin
                  stNext.rdData = 32'(stReg.globalMask);
               end
               default: begin
                  stNext.rdData = '0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         stReg <= '0;
      end else begin
         stReg <= stNext;
      end
   end

   assign rdData   = stReg.rdData;
   assign resValid = stReg.resValid;
   assign resPri   = stReg.resPri;
   assign resPcp   = stReg.resPcp;
   assign resMap   = stReg.resMap;
   assign irq      = stReg.irq;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   priNone_a: assert property (
      actApply && curPm == 2'h0 |=> resPri == $past(qosPri))
      else $error("priority changed with priority mode 00");

   priAlways_a: assert property (
      actApply && curPm == 2'h3 |=> resPri == $past(curPri))
      else $error("entry priority not applied with mode 11");

   priRaise_a: assert property (
      actApply && curPm == 2'h1 && curPri <= qosPri |=> resPri == $past(qosPri))
      else $error("priority raised when entry not greater");

   remarkOff_a: assert property (
      frmValid && !(actApply && curEntry[aac_pkg::F_REMARK_EN]) |=> resPcp == $past(framePcp))
      else $error("pcp remarked without remark enable");

   remarkOn_a: assert property (
      actApply && curEntry[aac_pkg::F_REMARK_EN]
      |=> resPcp == $past(curEntry[aac_pkg::F_RPRI_LSB +: 3]))
      else $error("pcp not remarked");

   mapOr_a: assert property (
      actApply && curMm == 2'h1 |=> resMap == ($past(lookupMap) | $past(curFwd)))
      else $error("map or mode wrong");

   mapReplace_a: assert property (
      actApply && curMm == 2'h3 |=> resMap == $past(curFwd))
      else $error("map replace mode wrong");

   entryOff_a: assert property (
      frmValid && portOk && !entryLive
      |=> resMap == $past(lookupMap) && resPri == $past(qosPri))
      else $error("disabled entry changed frame");

   statusCause_a: assert property (
      ##1 (stReg.portStatus & ~$past(stReg.portStatus) & ~$past(evPort)) == '0)
      else $error("status set without count event");

   statusHold_a: assert property (
      ##1 ($past(stReg.portStatus) & ~$past(statusClr) & ~stReg.portStatus) == '0)
      else $error("status dropped without clear");

   irqGate_a: assert property (
      ##1 irq == |(stReg.portStatus & stReg.portMask & stReg.globalMask))
      else $error("interrupt not gated by both masks");

endmodule : aac_action_count_unit

/* File: aac_action_count_unit_tb.sv */
// self-checking bench for the acl action and count unit
`timescale 1ns/1ns
module aac_action_count_unit_tb;
   // ----------------------------------------------------------------
   // signals and reference state
   // ----------------------------------------------------------------
   localparam int MSC = 40;
   logic        mclk   = 1'b0;
   logic        reset  = 1'b1;
   logic [7:0]  addr   = 8'h00;
   logic [31:0] wrData = 32'h00000000;
   logic        wrEn   = 1'b0;
   logic        rdEn   = 1'b0;
   logic [31:0] rdData;
   logic        frmValid, actHit, resValid, irq;
   logic [2:0]  frmPort, qosPri, framePcp, resPri, resPcp;
   logic [3:0]  actIdx;
   logic [15:0] cntHit;
   logic [6:0]  lookupMap, resMap;
   logic [23:0] tbl [112];
   logic [12:0] expQ [$];
   int          cycQ [$];
   logic [7:0]  ra [5] = '{8'h00, 8'h6F, 8'h80, 8'h81, 8'h83};
   int          fails = 0;
   int          comparisons = 0;
   int          edges = 0;

   always #25 mclk = ~mclk;
   always @(posedge mclk) edges <= edges + 1;

   aac_action_count_unit #(.MS_CYCLES(MSC)) u_aac_action_count_unit (
      .mclk(mclk), .reset(reset), .addr(addr), .wrData(wrData), .wrEn(wrEn),
      .rdEn(rdEn), .rdData(rdData), .frmValid(frmValid), .frmPort(frmPort),
      .actHit(actHit), .actIdx(actIdx), .cntHit(cntHit), .qosPri(qosPri),
      .framePcp(framePcp), .lookupMap(lookupMap), .resValid(resValid),
      .resPri(resPri), .resPcp(resPcp), .resMap(resMap), .irq(irq));
   aac_lookup_model u_aac_lookup_model (
      .mclk(mclk), .frmValid(frmValid), .frmPort(frmPort), .actHit(actHit),
      .actIdx(actIdx), .cntHit(cntHit), .qosPri(qosPri), .framePcp(framePcp),
      .lookupMap(lookupMap));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   // irq is looked at mid-cycle, clear of the edge that launches it
   task automatic irqChk(input logic e, input string m);
      @(negedge mclk);
      check({31'h0, irq}, {31'h0, e}, m);
      @(posedge mclk);
   endtask : irqChk

   task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr   <= a;
      wrData <= d;
      wrEn   <= 1'b1;
      @(posedge mclk);
      wrEn   <= 1'b0;
      @(posedge mclk);
   endtask : wr

   task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string m);
      logic [31:0] d;
      addr <= a;
      rdEn <= 1'b1;
      @(posedge mclk);
      rdEn <= 1'b0;
      @(negedge mclk);
      d = rdData;
      @(posedge mclk);
      check(d, e, m);
   endtask : rdChk

   function automatic logic [12:0] predict(input logic [2:0] p, input logic h,
      input logic [3:0] i, input logic [2:0] q, input logic [2:0] v, input logic [6:0] m);
      logic [23:0] e;
      logic [2:0]  pr;
      e  = tbl[p * 16 + i];
      pr = e[8:6];
      if (!h || e[23:22] == 2'h0 || e[23:20] == 4'h4) return {q, v, m};
      case (e[10:9])
         2'h0: pr = q;
         2'h1: if (pr <= q) pr = q;
         2'h2: if (pr >= q) pr = q;
         default: ;
      endcase
      if (e[5]) v = e[4:2];
      case (e[1:0])
         2'h1: m = m | e[19:13];
         2'h2: m = m & e[19:13];
         2'h3: m = e[19:13];
         default: ;
      endcase
      return {pr, v, m};
   endfunction : predict

   // result expected at the negedge after the taking edge
   task automatic frame(input logic [2:0] p, input logic h, input logic [3:0] i,
                        input logic [15:0] c, input logic [2:0] q, input logic [2:0] v,
                        input logic [6:0] m);
      if (p != 3'h7) begin
         expQ.push_back(predict(p, h, i, q, v, m));
         cycQ.push_back(edges + 2);
      end
      u_aac_lookup_model.drive(p, h, i, c, q, v, m);
   endtask : frame

   task automatic tmo(input logic [2:0] p, input logic [3:0] e, input logic [23:0] w,
                      input int early, input int late);
      tbl[p * 16 + e] = w;
      wr({1'b0, p, e}, {8'h00, w});
      repeat (4) begin
         frame(p, 1'b0, e, 16'h0001 << e, 3'h0, 3'h0, 7'h00);
         u_aac_lookup_model.idle();
         repeat (28) @(posedge mclk);
      end
      repeat (early) @(posedge mclk);
      rdChk(8'h80, 32'h00000000, "early expiry");
      repeat (late) @(posedge mclk);
      rdChk(8'h80, 32'h00000001 << p, "missing expiry");
      wr(8'h80, 32'h0000007F);
      $display("test timeout port %0d done", p);
   endtask : tmo

   // ----------------------------------------------------------------
   // result monitor
   // ----------------------------------------------------------------
   always @(negedge mclk) begin
      if (cycQ.size() > 0 && cycQ[0] == edges) begin
         check({18'h0, resValid, resPri, resPcp, resMap}, {19'h1, expQ[0]}, "result");
         void'(cycQ.pop_front());
         void'(expQ.pop_front());
      end else if (!reset && resValid !== 1'b0) begin
         check({31'h0, resValid}, 32'h0, "unexpected result");
      end
   end

   initial begin
      #(10000 * 50);
      fails++;
      $display("[FAIL] %0t watchdog ran out", $time);
      print_verdict();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(25));
      foreach (tbl[k]) tbl[k] = 24'h000000;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      foreach (ra[k]) rdChk(ra[k], 32'h00000000, "reset value");
      wr(8'h00, 32'hFFFFFFFF);
      rdChk(8'h00, 32'h00FFFFFF, "entry width");
      wr(8'h90, 32'hFFFFFFFF);
      rdChk(8'h90, 32'h00000000, "unmapped read");
      rdChk(8'h75, 32'h00000000, "unmapped read");
      wr(8'h81, 32'h0000007F);
      wr(8'h83, 32'h0000007F);
      wr(8'h82, 32'h0000007F);
      rdChk(8'h82, 32'h00000000, "global status write");
      $display("test registers done");
      foreach (tbl[k]) begin
         tbl[k] = 24'($urandom);
         wr(8'(k), {8'h00, tbl[k]});
      end
      repeat (300) frame(3'($urandom), 1'($urandom), 4'($urandom), 16'h0000,
                         3'($urandom), 3'($urandom), 7'($urandom));
      u_aac_lookup_model.idle();
      @(posedge mclk);
      irqChk(1'b0, "irq from filtering");
      rdChk(8'h80, 32'h00000000, "status from filtering");
      $display("test actions done");
      tbl[37] = 24'h401003;
      wr(8'h25, {8'h00, tbl[37]});
      tbl[53] = 24'h000000;
      wr(8'h35, 32'h00000000);
      for (int n = 1; n <= 6; n++) begin
         frame(3'h3, 1'b1, 4'h5, 16'h0020, 3'h1, 3'h2, 7'h11);
         frame(3'h2, 1'b1, 4'h5, 16'h0020, 3'h1, 3'h2, 7'h11);
         u_aac_lookup_model.idle();
         @(posedge mclk);
         rdChk(8'h80, (n % 3 == 0) ? 32'h4 : 32'h0, "frame count");
         irqChk(n % 3 == 0, "count irq");
         if (n == 3) wr(8'h80, 32'h00000004);
      end
      wr(8'h81, 32'h0000007B);
      rdChk(8'h82, 32'h00000000, "global fold");
      irqChk(1'b0, "port mask");
      wr(8'h81, 32'h0000007F);
      wr(8'h83, 32'h0000007B);
      rdChk(8'h82, 32'h00000004, "global fold");
      irqChk(1'b0, "global mask");
      wr(8'h83, 32'h0000007F);
      rdChk(8'h80, 32'h00000004, "latched status");
      irqChk(1'b1, "both masks");
      wr(8'h80, 32'h00000004);
      rdChk(8'h80, 32'h00000000, "status clear");
      irqChk(1'b0, "irq clear");
      $display("test count done");
      // expiry lands 42..61 edges (us, count 3) or 42..81 edges (ms, count 2) after the last load
      tmo(3'h0, 4'h1, 24'h400003, 5, 30);
      tmo(3'h1, 4'h0, 24'h400802, 5, 50);
      print_verdict();
   end
endmodule : aac_action_count_unit_tb

/* File: aac_lookup_model.sv */
// far-side model: lookup and classification results fed to the unit
`timescale 1ns/1ns
module aac_lookup_model (
   // clock
   input  wire logic        mclk,
   // frame decision request
   output logic             frmValid,
   output logic [2:0]       frmPort,
   output logic             actHit,
   output logic [3:0]       actIdx,
   output logic [15:0]      cntHit,
   output logic [2:0]       qosPri,
   output logic [2:0]       framePcp,
   output logic [6:0]       lookupMap
);
   initial begin
      {frmValid, frmPort, actHit, actIdx, cntHit, qosPri, framePcp, lookupMap} = '0;
   end

   // one frame, taken at the next rising edge
   task automatic drive(input logic [2:0] p, input logic h, input logic [3:0] i,
                        input logic [15:0] c, input logic [2:0] q, input logic [2:0] v,
                        input logic [6:0] m);
      frmValid  <= 1'b1;
      frmPort   <= p;
      actHit    <= h;
      actIdx    <= i;
      cntHit    <= c;
      qosPri    <= q;
      framePcp  <= v;
      lookupMap <= m;
      @(posedge mclk);
   endtask : drive

   // released lines carry inverted data so stale values cannot pass
   task automatic idle();
      frmValid <= 1'b0;
      {frmPort, actHit, actIdx, cntHit, qosPri, framePcp, lookupMap} <=
         ~{frmPort, actHit, actIdx, cntHit, qosPri, framePcp, lookupMap};
      @(posedge mclk);
   endtask : idle
endmodule : aac_lookup_model

/* File: aac_pkg.sv */
// constants and state type for the acl action and count unit
//
// Overview of operation
// - priority mode 00 keeps QoS, 01 raises only, 10 lowers only, 11 always
// - remark enable set replaces frame PCP bits with remark priority value
// - map mode 00 keeps, 01 ORs, 10 ANDs, 11 replaces lookup port map
// - port map bit n stands for port n+1; set bit forwards there
// - time unit bit picks microsecond (0) or millisecond (1) counter tick
// - algorithm 0 loads 11-bit down-counter, interrupt if it expires first
// - algorithm 1 counts matching frames, interrupts at terminal count, then restarts
// - sixteen entries per port, matching and action fields stored together
// - count mode (match mode 01, select 00) reads action as count parameters
// - filtering and forwarding actions never raise interrupts; only count mode does
// - each port has its own count interrupt status bit and mask bit
// - port interrupts fold into global per-port status with global mask
// - count value is priority mode, priority, remark fields and map mode concatenated
// - match mode 00 disables entry: no action and no counting
package aac_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NPORT       = 7;
   localparam int TBL_DEPTH   = 16;
   localparam int TBL_ENTRIES = NPORT * TBL_DEPTH;
   localparam int ENTRY_W     = 24;
   localparam int CNT_W       = 11;
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 32;

   // ----------------------------------------------------------------
   // entry field positions
   // ----------------------------------------------------------------
   localparam int F_MMODE_LSB = 22;
   localparam int F_MSEL_LSB  = 20;
   localparam int F_FWD_LSB   = 13;
   localparam int F_ALGO      = 12;
   localparam int F_TUNIT     = 11;
   localparam int F_PMODE_LSB = 9;
   localparam int F_PRI_LSB   = 6;
   localparam int F_REMARK_EN = 5;
   localparam int F_RPRI_LSB  = 2;
   localparam int F_MAPM_LSB  = 0;
   localparam int F_COUNT_LSB = 0;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_OFF   = 2'h0;
   localparam logic [1:0] MODE_L2    = 2'h1;
   localparam logic [1:0] SEL_COUNT  = 2'h0;
   localparam logic [1:0] SEL_RAISE  = 2'h1;
   localparam logic [1:0] SEL_LOWER  = 2'h2;
   localparam logic [1:0] SEL_ALWAYS = 2'h3;

   // ----------------------------------------------------------------
   // register addresses (table entry k sits at address k)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_PORT_STATUS = 8'h80;
   localparam logic [7:0] ADDR_PORT_MASK   = 8'h81;
   localparam logic [7:0] ADDR_GLOB_STATUS = 8'h82;
   localparam logic [7:0] ADDR_GLOB_MASK   = 8'h83;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int US_NS         = 1000;
   localparam int MS_NS         = 1000000;
   localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic [TBL_ENTRIES-1:0][ENTRY_W-1:0] tbl;
      logic [TBL_ENTRIES-1:0][CNT_W-1:0]   cnt;
      logic [TBL_ENTRIES-1:0]              armed;
      logic [4:0]                          usDiv;
      logic [15:0]                         msDiv;
      logic [NPORT-1:0]                    portStatus;
      logic [NPORT-1:0]                    portMask;
      logic [NPORT-1:0]                    globalMask;
      logic                                resValid;
      logic [2:0]                          resPri;
      logic [2:0]                          resPcp;
      logic [NPORT-1:0]                    resMap;
      logic                                irq;
      logic [DATA_W-1:0]                   rdData;
   } aac_state_t;

endpackage : aac_pkg
